// ===== src/hex_loader_regs.vh
/*
 constants of the serial hex flash loader: characters, record types,
 message codes, security value, timing figures.
 assumes inclusion by bare name from the loader sources.
*/
`ifndef HEX_LOADER_REGS_VH
`define HEX_LOADER_REGS_VH
`define CH_COLON      8'h3A
`define CH_PERIOD     8'h2E
`define CH_X          8'h58
`define CH_Y          8'h59
`define CH_Z          8'h5A
`define CH_R          8'h52
`define CH_V          8'h56
`define CH_XON        8'h11
`define CH_XOFF       8'h13
`define REC_DATA      8'h00
`define REC_END       8'h01
`define SEC_ACTIVE    8'h50
`define ERASED_BYTE   8'hFF
`define BOOT_VECTOR   16'h0000
`define BOOT_SEL_ON   2'h3
`define CLK_MHZ       200
`define BAUD_MIN      1200
`define BAUD_MAX      19200
`define WRITE_US      2500
`define ERASE_US      5000
`define PAGE_BITS     5
`endif

// ===== src/hex_byte_buffer.v
/*
 two-entry buffer with valid/ready on both sides.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module hex_byte_buffer #(
   parameter WIDTH = 8
)(
   // clock and reset
   input  wire             clk_sys,
   input  wire             rstn,
   // fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   // fill level
   output wire [1:0]       level
);
   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   reg [1:0]       count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = slot0;
   assign level     = count;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // slot0 is head; slot1 holds the second word
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         count <= 2'h0;
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
      end
      else
      begin
         case ({push, pop})
            2'b10:
            begin
               if (count == 2'h0)
                  slot0 <= in_data;
               else
                  slot1 <= in_data;
               count <= count + 2'h1;
            end
            2'b01:
            begin
               slot0 <= slot1;
               count <= count - 2'h1;
            end
            2'b11:
            begin
               if (count == 2'h1)
                  slot0 <= in_data;
               else
               begin
                  slot0 <= slot1;
                  slot1 <= in_data;
               end
            end
            default:
               count <= count;
         endcase
      end
   end
endmodule // hex_byte_buffer

// ===== src/hex_flash_loader.v
/*
 serial hex-record flash loader: autobaud on ':', record parse, checksum,
 page erase/rewrite or full erase, flash program with verify, Xon/Xoff
 pacing and one-character status messages.
 assumes rxd/strap pins are asynchronous, flash array lives inside.
*/
`timescale 1ns/1ps
`include "hex_loader_regs.vh"
// Behaviour
// - boot entry sets both boot-select bits and starts at address zero.
// - frames are start, eight data bits, stop; same rate both ways.
// - 4800 and 9600 baud supported.
// - rate measured from first colon; undetected rate means silence.
// - programming starts only if first record type is valid.
// - security byte 50H forces full erase; else page erase and rewrite.
// - reception continues during flash work, paced by Xon/Xoff.
// - period sent after each data record.
// - X checksum, Y bad type, Z overflow, R verify failure.
// - V sent on end record after successful programming.
// - failure halts until reset; success leaves user start at zero.
// - autobaud covers 1200 to 19200 baud; at 200 MHz the 18-bit count of the two-bit low run wraps below about 1526 baud.
// - any bytes, any order; full erase leaves FFH.
// - byte count 0 to 255.
// - type 00 data, 01 end.
// - two's complement checksum; valid record sums to zero.
// - colon, count, address, type, data, checksum as hex digits.
// - records any order, bytes consecutive from load address.
// - characters between checksum and colon ignored.
// - end record address field may hold a file checksum.
// - secure mode lets boot logic load only full-erase code; the verify after the full erase always fails, so the loader halts with R.
module hex_flash_loader #(
   parameter ADDR_W   = 15,
   parameter CLK_HZ   = `CLK_MHZ * 1000000,
   parameter WRITE_CY = `WRITE_US * `CLK_MHZ,
   parameter ERASE_CY = `ERASE_US * `CLK_MHZ
)(
   // clock and reset
   input  wire        clk_sys,
   input  wire        rstn,
   // boot straps and soft entry
   input  wire        program_store_strobe_n,
   input  wire        external_access_n,
   input  wire        soft_boot,
   input  wire [7:0]  flash_mode_control,
   // serial link
   input  wire        rxd,
   output reg         txd,
   // status
   output reg  [1:0]  boot_select_bits,
   output reg  [15:0] start_address,
   output reg         boot_active,
   output reg         done_ok,
   output reg         halted
);
   localparam BIT_MAX = CLK_HZ / `BAUD_MIN;
   localparam BIT_MIN = CLK_HZ / `BAUD_MAX;
   localparam [3:0] S_IDLE = 4'h1, S_FIELD = 4'h2, S_DONE = 4'h4,
                    S_SKIP = 4'h8;
   localparam [2:0] F_HDR = 3'h1, F_DATA = 3'h2, F_SUM = 3'h4;
   localparam [3:0] P_IDLE = 4'h1, P_ERASE = 4'h2, P_WRITE = 4'h4,
                    P_FULL = 4'h8;
   localparam DEPTH = 1 << ADDR_W;
   localparam PAGE_SZ = 1 << `PAGE_BITS;

   reg [7:0]  flash [0:DEPTH-1];
   reg [7:0]  page_img [0:(1<<`PAGE_BITS)-1];
   reg [2:0]  rx_sync;
   reg [1:0]  strap_a, strap_b, strap_c;
   reg        baud_ok;
   reg [17:0] bit_len;
   reg [17:0] bcnt;
   reg [3:0]  rx_bit;
   reg        rx_busy;
   reg [7:0]  rx_shift;
   reg        rx_strobe;
   reg        meas;
   reg [3:0]  st;
   reg [2:0]  fld;
   reg [3:0]  nib_cnt;
   reg [3:0]  hi_nib;
   reg [7:0]  sum;
   reg [7:0]  rec_len;
   reg [7:0]  data_left;
   reg [15:0] rec_addr;
   reg [7:0]  rec_type;
   reg [3:0]  hdr_idx;
   reg        first_rec;
   reg        started;
   reg        fail;
   reg        secure;
   reg        full_done;
   reg [3:0]  pst;
   reg [22:0] ptimer;
   reg [4:0]  pidx;
   reg [15:0] paddr;
   reg [7:0]  pdata;
   reg [7:0]  tx_char;
   reg        tx_req;
   reg [3:0]  tx_bit;
   reg [17:0] tx_cnt;
   reg [9:0]  tx_shift;
   reg        tx_busy;
   reg        xoff_sent;
   reg        buf_pop;
   wire       rx_in;
   wire       in_ready;
   wire       out_valid;
   wire [7:0] out_data;
   wire [1:0] level;

   // convert an ASCII hex digit to its value
   function [3:0] hex_val;
      input [7:0] c;
      begin
         if (c >= 8'h61)
            hex_val = c[3:0] + 4'h9;
         else if (c >= 8'h41)
            hex_val = c[3:0] + 4'h9;
         else
            hex_val = c[3:0];
      end
   endfunction

   reg rx_in_q;

   // the stable sample is where the second and third stage agree
   assign rx_in = (rx_sync[2] == rx_sync[1]) ? rx_sync[2] : rx_in_q;

   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         rx_sync <= 3'h7;
         rx_in_q <= 1'b1;
      end
      else
      begin
         rx_sync <= {rx_sync[1:0], rxd};
         rx_in_q <= rx_in;
      end
   end

   // strap sampling after reset release; boot entry
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         strap_a <= 2'h3;
         strap_b <= 2'h3;
         strap_c <= 2'h3;
         boot_select_bits <= 2'h0;
         boot_active <= 1'b0;
         start_address <= `BOOT_VECTOR;
      end
      else
      begin
         strap_a <= {program_store_strobe_n, external_access_n};
         strap_b <= strap_a;
         strap_c <= strap_b;
         if (!boot_active && ((strap_b == 2'h0 && strap_c == 2'h0) ||
             (soft_boot && flash_mode_control == 8'h40)))
         begin
            boot_active <= 1'b1;
            boot_select_bits <= `BOOT_SEL_ON;
            start_address <= `BOOT_VECTOR;
         end
      end
   end

   // receiver with autobaud on the first low run of ':', falling edge to rising edge
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         baud_ok <= 1'b0;
         bit_len <= 18'h0;
         bcnt <= 18'h0;
         rx_bit <= 4'h0;
         rx_busy <= 1'b0;
         rx_shift <= 8'h0;
         rx_strobe <= 1'b0;
         meas <= 1'b0;
      end
      else
      begin
         rx_strobe <= 1'b0;
         if (!boot_active)
            meas <= 1'b0;
         else if (!baud_ok)
         begin
            // ':' = 0x3A: start bit plus bit0 low -> low run of 2 bits
            if (!meas && !rx_in)
            begin
               meas <= 1'b1;
               bcnt <= 18'h0;
            end
            else if (meas && !rx_in)
               bcnt <= bcnt + 18'h1;
            else if (meas && rx_in)
            begin
               meas <= 1'b0;
               if (bcnt[17:1] >= BIT_MIN && bcnt[17:1] <= BIT_MAX)
               begin
                  baud_ok <= 1'b1;
                  bit_len <= {1'b0, bcnt[17:1]};
                  rx_busy <= 1'b1;
                  rx_bit <= 4'h2;
                  rx_shift <= 8'h0;
                  bcnt <= {1'b0, bcnt[17:1]};
               end
            end
         end
         else if (!rx_busy)
         begin
            if (!rx_in)
            begin
               rx_busy <= 1'b1;
               rx_bit <= 4'h0;
               bcnt <= {1'b0, bit_len[17:1]};   // sample mid bit
            end
         end
         else if (bcnt >= bit_len)
         begin
            bcnt <= 18'h0;
            if (rx_bit == 4'h9)
            begin
               rx_busy <= 1'b0;
               rx_strobe <= 1'b1;
            end
            else
            begin
               if (rx_bit != 4'h0)
                  rx_shift <= {rx_in, rx_shift[7:1]};
               rx_bit <= rx_bit + 4'h1;
            end
         end
         else
            bcnt <= bcnt + 18'h1;
      end
   end

   hex_byte_buffer #(
      .WIDTH     (8)
   ) u_buf (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_valid  (rx_strobe),
      .in_ready  (in_ready),
      .in_data   (baud_ok && rx_bit == 4'h9 ? rx_shift : `CH_COLON),
      .out_valid (out_valid),
      .out_ready (buf_pop),
      .out_data  (out_data),
      .level     (level)
   );

   // record parser and flash sequencer
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         st <= S_IDLE; fld <= F_HDR; nib_cnt <= 4'h0; hi_nib <= 4'h0;
         sum <= 8'h0; rec_len <= 8'h0; data_left <= 8'h0;
         rec_addr <= 16'h0; rec_type <= 8'h0; hdr_idx <= 4'h0;
         first_rec <= 1'b1; started <= 1'b0; fail <= 1'b0;
         secure <= 1'b0; full_done <= 1'b0; pst <= P_IDLE;
         ptimer <= 23'h0; pidx <= 5'h0; paddr <= 16'h0; pdata <= 8'h0;
         tx_req <= 1'b0; tx_char <= 8'h0; buf_pop <= 1'b0;
         done_ok <= 1'b0; halted <= 1'b0;
      end
      else
      begin
         tx_req <= 1'b0;
         buf_pop <= 1'b0;
         secure <= (flash[DEPTH-1] == `SEC_ACTIVE);
         if (rx_strobe && !in_ready && !halted && !done_ok)
         begin
            tx_char <= `CH_Z; tx_req <= 1'b1;
            fail <= 1'b1; halted <= 1'b1;
         end
         case (pst)
            P_IDLE:
            begin
               if (out_valid && !buf_pop && !halted && !done_ok &&
                   !tx_busy && !tx_req)
               begin
                  buf_pop <= 1'b1;
                  case (st)
                     S_IDLE, S_SKIP:
                        if (out_data == `CH_COLON)
                        begin
                           st <= S_FIELD; fld <= F_HDR;
                           hdr_idx <= 4'h0; nib_cnt <= 4'h0; sum <= 8'h0;
                        end
                     S_FIELD:
                     begin
                        nib_cnt <= nib_cnt + 4'h1;
                        if (!nib_cnt[0])
                           hi_nib <= hex_val(out_data);
                        else
                        begin
                           pdata <= {hi_nib, hex_val(out_data)};
                           sum <= sum + {hi_nib, hex_val(out_data)};
                           case (fld)
                              F_HDR:
                              begin
                                 hdr_idx <= hdr_idx + 4'h1;
                                 if (hdr_idx == 4'h0)
                                    rec_len <= {hi_nib, hex_val(out_data)};
                                 else if (hdr_idx == 4'h1)
                                    rec_addr[15:8] <= {hi_nib, hex_val(out_data)};
                                 else if (hdr_idx == 4'h2)
                                    rec_addr[7:0] <= {hi_nib, hex_val(out_data)};
                                 else
                                 begin
                                    rec_type <= {hi_nib, hex_val(out_data)};
                                    data_left <= rec_len;
                                    fld <= (rec_len == 8'h0) ? F_SUM : F_DATA;
                                 end
                              end
                              F_DATA:
                              begin
                                 data_left <= data_left - 8'h1;
                                 if (data_left == 8'h1)
                                    fld <= F_SUM;
                                 if (rec_type == `REC_DATA && started)
                                 begin
                                    paddr <= rec_addr;
                                    rec_addr <= rec_addr + 16'h1;
                                    pidx <= 5'h0;
                                    ptimer <= 23'h0;
                                    pst <= secure ? P_WRITE : P_ERASE;
                                 end
                              end
                              default:
                              begin
                                 st <= S_SKIP;
                                 if (sum + {hi_nib, hex_val(out_data)} != 8'h0)
                                 begin
                                    tx_char <= `CH_X; tx_req <= 1'b1;
                                    fail <= 1'b1; halted <= 1'b1;
                                 end
                                 else if (rec_type == `REC_DATA)
                                 begin
                                    tx_char <= `CH_PERIOD;
                                    tx_req <= 1'b1;
                                 end
                                 else if (rec_type == `REC_END)
                                 begin
                                    tx_char <= fail ? `CH_R : `CH_V;
                                    tx_req <= 1'b1;
                                    done_ok <= ~fail;
                                    halted <= fail;
                                 end
                              end
                           endcase
                           // first record type gates start of programming
                           if (fld == F_HDR && hdr_idx == 4'h3)
                           begin
                              if ({hi_nib, hex_val(out_data)} > `REC_END)
                              begin
                                 tx_char <= `CH_Y; tx_req <= 1'b1;
                                 fail <= 1'b1; halted <= 1'b1;
                              end
                              else if (first_rec)
                              begin
                                 first_rec <= 1'b0;
                                 started <= 1'b1;
                                 if (secure && !full_done)
                                 begin
                                    pst <= P_FULL; ptimer <= 23'h0;
                                    pidx <= 5'h0;
                                 end
                              end
                           end
                        end
                     end
                     default:
                        st <= S_IDLE;
                  endcase
               end
            end
            P_FULL:
            begin
               ptimer <= ptimer + 23'h1;
               // sweep the whole array, at least for the erase time
               if (ptimer < DEPTH)
                  flash[ptimer[ADDR_W-1:0]] <= `ERASED_BYTE;
               if (ptimer >= ERASE_CY && ptimer >= DEPTH)
               begin
                  full_done <= 1'b1; pst <= P_IDLE;
               end
            end
            P_ERASE:
            begin
               // save the page image and erase the page, a byte a cycle
               if (ptimer < PAGE_SZ)
               begin
                  page_img[pidx] <= flash[{paddr[ADDR_W-1:`PAGE_BITS], pidx}];
                  flash[{paddr[ADDR_W-1:`PAGE_BITS], pidx}] <= `ERASED_BYTE;
                  pidx <= pidx + 5'h1;
               end
               ptimer <= ptimer + 23'h1;
               if (ptimer >= ERASE_CY)
               begin
                  ptimer <= 23'h0; pst <= P_WRITE;
               end
            end
            P_WRITE:
            begin
               ptimer <= ptimer + 23'h1;
               // put back the page bytes that this write leaves alone
               if (!secure && ptimer < PAGE_SZ)
               begin
                  flash[{paddr[ADDR_W-1:`PAGE_BITS], pidx}] <= page_img[pidx];
                  pidx <= pidx + 5'h1;
               end
               if (ptimer >= WRITE_CY)
               begin
                  flash[paddr[ADDR_W-1:0]] <= pdata;
                  pst <= P_IDLE;
               end
            end
            default:
               pst <= P_IDLE;
         endcase
         if (pst == P_IDLE && ptimer != 23'h0 &&
             flash[paddr[ADDR_W-1:0]] != pdata && started && !secure)
         begin
            tx_char <= `CH_R; tx_req <= 1'b1; fail <= 1'b1;
            halted <= 1'b1;
         end
         if (pst == P_IDLE)
            ptimer <= 23'h0;
      end
   end

   // transmitter with Xon/Xoff pacing
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         txd <= 1'b1; tx_bit <= 4'h0; tx_cnt <= 18'h0;
         tx_shift <= 10'h3FF; tx_busy <= 1'b0; xoff_sent <= 1'b0;
      end
      else if (tx_busy)
      begin
         if (tx_cnt >= bit_len)
         begin
            tx_cnt <= 18'h0;
            txd <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'hA)
               tx_busy <= 1'b0;
         end
         else
            tx_cnt <= tx_cnt + 18'h1;
      end
      else if (baud_ok)
      begin
         if (tx_req)
         begin
            tx_shift <= {1'b1, tx_char, 1'b0};
            tx_busy <= 1'b1; tx_bit <= 4'h0; tx_cnt <= bit_len;
         end
         else if (!xoff_sent && pst != P_IDLE && level != 2'h0)
         begin
            tx_shift <= {1'b1, `CH_XOFF, 1'b0};
            tx_busy <= 1'b1; tx_bit <= 4'h0; tx_cnt <= bit_len;
            xoff_sent <= 1'b1;
         end
         else if (xoff_sent && pst == P_IDLE && level == 2'h0)
         begin
            tx_shift <= {1'b1, `CH_XON, 1'b0};
            tx_busy <= 1'b1; tx_bit <= 4'h0; tx_cnt <= bit_len;
            xoff_sent <= 1'b0;
         end
      end
   end
endmodule // hex_flash_loader

// ===== sim/hex_loader_checker.sv
/*
 concurrent checks on the ports of the hex flash loader.
 assumes one clock, clk_sys, and the synchronous active-low rstn.
*/
`timescale 1ns/1ps
module hex_loader_checker (
   // clock and reset
   input wire        clk_sys,
   input wire        rstn,
   // straps and soft entry
   input wire        program_store_strobe_n,
   input wire        external_access_n,
   input wire        soft_boot,
   input wire [7:0]  flash_mode_control,
   // serial and status
   input wire        txd,
   input wire [1:0]  boot_select_bits,
   input wire [15:0] start_address,
   input wire        boot_active,
   input wire        done_ok,
   input wire        halted
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // entry paths and boot state
   a_strap_entry: assert property ($rose(rstn) && !program_store_strobe_n
      && !external_access_n |-> ##[1:6] boot_active)
      else $error("no boot entry after strap reset");
   a_soft_entry: assert property (soft_boot
      && flash_mode_control == 8'h40 |-> ##[1:8] boot_active)
      else $error("no boot entry on soft jump");
   a_sel_bits: assert property (boot_active |-> boot_select_bits == 2'h3)
      else $error("boot select bits wrong in boot mode");
   a_start_zero: assert property (start_address == 16'h0000)
      else $error("start address not zero");
   // outcome flags hold until reset
   a_done_holds: assert property (done_ok |=> done_ok)
      else $error("done flag dropped");
   a_halt_holds: assert property (halted |=> halted)
      else $error("halt flag dropped");
   a_ok_or_halt: assert property (!(done_ok && halted))
      else $error("done and halted together");
   // serial frame shape
   a_start_bit: assert property ($fell(txd) |=> !txd [*8])
      else $error("start bit too short");
   a_bit_high: assert property ($rose(txd) |=> txd [*8])
      else $error("high bit too short");
   a_tx_in_boot: assert property ($fell(txd) |-> boot_active)
      else $error("transmit outside boot mode");
   c_done: cover property ($rose(done_ok));
   c_halt: cover property ($rose(halted));
   c_tx: cover property ($fell(txd));
   c_soft: cover property (soft_boot && flash_mode_control == 8'h40);
endmodule // hex_loader_checker
bind hex_flash_loader hex_loader_checker u_chk (.clk_sys(clk_sys),
   .rstn(rstn), .program_store_strobe_n(program_store_strobe_n),
   .external_access_n(external_access_n), .soft_boot(soft_boot),
   .flash_mode_control(flash_mode_control), .txd(txd),
   .boot_select_bits(boot_select_bits), .start_address(start_address),
   .boot_active(boot_active), .done_ok(done_ok), .halted(halted));

// ===== sim/hex_host_model.sv
/*
 host terminal: sends characters on rxd, collects replies from txd and
 obeys Xon/Xoff pacing.
 assumes clk_sys at 200 MHz and a link of 19200 baud.
*/
`timescale 1ns/1ps
module hex_host_model #(
   parameter BIT = 10417
)(
   input wire clk_sys,
   input wire txd,
   output reg rxd
);
   logic [7:0] rx_q[$];
   logic       paused;
   logic [7:0] b;
   initial rxd = 1'b1;
   initial paused = 1'b0;
   // one frame: start, eight data bits lsb first, one stop bit
   task send_char(input logic [7:0] c);
      int i;
      while (paused) @(negedge clk_sys);
      rxd = 1'b0;
      repeat (BIT) @(negedge clk_sys);
      for (i = 0; i < 8; i++)
      begin
         rxd = c[i];
         repeat (BIT) @(negedge clk_sys);
      end
      rxd = 1'b1;
      repeat (BIT) @(negedge clk_sys);
   endtask
   task send_str(input string s);
      int i;
      for (i = 0; i < s.len(); i++) send_char(s[i]);
   endtask
   // receiver: pacing codes steer the sender, others are queued
   always
   begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge clk_sys);
         b[i] = txd;
      end
      repeat (BIT) @(posedge clk_sys);
      if (b == 8'h11) paused = 1'b0;
      else if (b == 8'h13) paused = 1'b1;
      else rx_q.push_back(b);
   end
endmodule // hex_host_model

// ===== sim/serial_hex_flash_loader_tb.sv
/*
 self-checking bench for the hex flash loader: records built and scored
 by a small model, replies compared, boot entry paths exercised.
 assumes the host model on the serial pins at 19200 baud.
*/
`timescale 1ns/1ps
module serial_hex_flash_loader_tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic program_store_strobe_n = 1'b0;
   logic external_access_n = 1'b0;
   logic soft_boot = 1'b0;
   logic [7:0] flash_mode_control = 8'h00;
   wire rxd, txd, boot_active, done_ok, halted;
   wire [1:0] boot_select_bits;
   wire [15:0] start_address;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] d0, d1;
   logic [15:0] a;
   always #2.5 clk_sys = ~clk_sys;
   // a scaled clock figure: one bit at 19200 baud lasts 100 cycles; the host bit is 101
   hex_flash_loader #(.CLK_HZ(1920000), .WRITE_CY(50), .ERASE_CY(100))
   u_dut (
      .clk_sys(clk_sys), .rstn(rstn),
      .program_store_strobe_n(program_store_strobe_n),
      .external_access_n(external_access_n), .soft_boot(soft_boot),
      .flash_mode_control(flash_mode_control), .rxd(rxd), .txd(txd),
      .boot_select_bits(boot_select_bits), .start_address(start_address),
      .boot_active(boot_active), .done_ok(done_ok), .halted(halted));
   hex_host_model #(.BIT(101)) u_host (.clk_sys(clk_sys), .txd(txd),
      .rxd(rxd));
   task end_sim;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task do_reset;
      @(negedge clk_sys);
      rstn = 1'b0;
      repeat (5) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (6) @(negedge clk_sys);
   endtask
   // build one record, score it with the model and compare the reply
   task rec(input logic [7:0] typ, input logic [15:0] ad,
            input int n, input logic [7:0] bad);
      string s;
      logic [7:0] sum, e, got;
      int k;
      sum = n + ad[15:8] + ad[7:0] + typ;
      s = $sformatf(":%02X%04X%02X", n[7:0], ad, typ);
      if (n > 0) s = {s, $sformatf("%02X", d0)};
      if (n > 0) sum = sum + d0;
      if (n > 1) s = {s, $sformatf("%02X", d1)};
      if (n > 1) sum = sum + d1;
      sum = (8'h00 - sum) ^ bad;
      s = {s, $sformatf("%02X", sum), "\r\n"};
      e = (bad != 0) ? 8'h58 : (typ == 0) ? 8'h2E : (typ == 1) ? 8'h56 : 8'h59;
      u_host.send_str(s);
      k = 0;
      while (u_host.rx_q.size() == 0 && k < 4000)
      begin
         @(posedge clk_sys);
         k++;
      end
      got = (u_host.rx_q.size() > 0) ? u_host.rx_q.pop_front() : 8'h00;
      chk(got, e);
   endtask
   // hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         fail_count++;
         end_sim;
      end
   end
   initial
   begin
      void'($urandom(32'hee73c438));
      // start from an erased, unsecured array
      for (int i = 0; i < 32768; i++) u_dut.flash[i] = 8'hFF;
      do_reset;
      chk(boot_active, 1'b1);
      chk(boot_select_bits, 2'h3);
      chk(start_address, 16'h0000);
      chk(txd, 1'b1);
      d0 = $urandom;
      d1 = $urandom;
      a = ($urandom % 16'h7000) + 16'h0100;
      rec(8'h00, a, 2, 8'h00);
      rec(8'h00, 16'h0000, 1, 8'h00);
      rec(8'h01, 16'h1234, 0, 8'h00);
      chk(done_ok, 1'b1);
      chk(halted, 1'b0);
      chk(u_dut.flash[a[14:0]], d0);
      chk(u_dut.flash[a[14:0] + 15'h1], d1);
      chk(u_dut.flash[0], d0);
      chk(u_dut.flash[1], 8'hFF);
      external_access_n = 1'b1;
      do_reset;
      chk(boot_active, 1'b0);
      chk(start_address, 16'h0000);
      flash_mode_control = 8'h40;
      soft_boot = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk(boot_active, 1'b1);
      soft_boot = 1'b0;
      flash_mode_control = 8'h00;
      external_access_n = 1'b0;
      do_reset;
      rec(8'h00, 16'h0200, 1, 8'h01);
      repeat (20) @(negedge clk_sys);
      chk(halted, 1'b1);
      do_reset;
      rec(8'h02, 16'h0000, 0, 8'h00);
      chk(done_ok, 1'b0);
      end_sim;
   end
endmodule // serial_hex_flash_loader_tb
